// *** core/apms_defines.svh ***
`ifndef APMS_DEFINES_SVH
`define APMS_DEFINES_SVH
`define APMS_CLK_MHZ          125
`define APMS_T_SOA_QUAL_US    300
`define APMS_T_MISS_QUAL_US   80
`define APMS_T_OFF_MS         16
`define APMS_T_SOFT_MUTE_MS   20
`define APMS_T_FAST_MUTE_US   100
`define APMS_CYC_SOA_QUAL     (`APMS_T_SOA_QUAL_US * `APMS_CLK_MHZ)
`define APMS_CYC_MISS_QUAL    (`APMS_T_MISS_QUAL_US * `APMS_CLK_MHZ)
`define APMS_CYC_OFF          (`APMS_T_OFF_MS * 1000 * `APMS_CLK_MHZ)
`define APMS_CYC_SOFT_MUTE    (`APMS_T_SOFT_MUTE_MS * 1000 * `APMS_CLK_MHZ)
`define APMS_CYC_FAST_MUTE    (`APMS_T_FAST_MUTE_US * `APMS_CLK_MHZ)
`define APMS_REG_INSTR_ONE    8'h00
`define APMS_REG_INSTR_TWO    8'h04
`define APMS_REG_STATUS       8'h08
`define APMS_REG_STATE        8'h0c
`define APMS_I1_START         0
`define APMS_I2_FAST_MUTE     0
`define APMS_I2_SOFT_FRONT    1
`define APMS_I2_SOFT_REAR     2
`define APMS_I2_LOW_POP_OFF   3
`define APMS_I2_FAULT_INDICATOR_PIN_LOAD_OFF 4
`define APMS_ST_RESET_FLAG    7
`define APMS_ST_LEGACY        4
`define APMS_I1_RST           8'h00
`define APMS_I2_RST           8'h00
`endif

// *** core/apms_pkg.sv ***
package apms_pkg;
   typedef enum logic [3:0] {
      ST_STANDBY, ST_POR, ST_RAMP, ST_RUN, ST_FAST_MUTE, ST_SHUTDOWN, ST_HR, ST_LOW_SUPPLY
   } apms_state_t;
endpackage

// *** core/apms_chan_if.sv ***
interface apms_chan_if;
   logic active;
   logic cond_soa_low;
   logic cond_soa_high;
   logic cond_miss;
   logic chan_on;
   modport ctl  (output active, output cond_soa_low, output cond_soa_high, output cond_miss,
                 input chan_on);
   modport chan (input active, input cond_soa_low, input cond_soa_high, input cond_miss,
                 output chan_on);
endinterface

// *** core/apms_chan_prot.sv ***
module apms_chan_prot #(
   parameter int SOA_Q  = 37500,
   parameter int MISS_Q = 10000,
   parameter int OFF_C  = 2000000
) (
   input wire logic   clock,
   input wire logic   sys_rst,
   apms_chan_if.chan  pif
);
   localparam int W = $clog2(OFF_C + SOA_Q + MISS_Q + 1);
   if (SOA_Q < 2 || MISS_Q < 2 || OFF_C < 2) begin : g_chk
      $error("apms_chan_prot: counts must be at least 2");
   end

   logic         on_r;
   logic         on_nxt;
   logic [W-1:0] soa_r;
   logic [W-1:0] soa_nxt;
   logic [W-1:0] miss_r;
   logic [W-1:0] miss_nxt;
   logic [W-1:0] off_r;
   logic [W-1:0] off_nxt;

   wire live      = pif.active & on_r;
   wire trip_soa  = live & pif.cond_soa_low & (soa_r == W'(SOA_Q - 1));
   wire trip_miss = live & pif.cond_miss & (miss_r == W'(MISS_Q - 1));
   wire trip      = live & (pif.cond_soa_high | trip_soa | trip_miss);
   wire off_done  = !on_r & (off_r == W'(OFF_C - 1));

   // Counters run per channel so one trip never touches its neighbours
   assign soa_nxt  = (live & pif.cond_soa_low & !trip) ? soa_r + W'(1) : '0;
   assign miss_nxt = (live & pif.cond_miss & !trip) ? miss_r + W'(1) : '0;
   assign off_nxt  = on_r ? '0 : off_r + W'(1);
   assign on_nxt   = !pif.active ? 1'b1 : trip ? 1'b0 : off_done ? 1'b1 : on_r;
   assign pif.chan_on = on_r;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         on_r   <= 1'b1;
         soa_r  <= '0;
         miss_r <= '0;
         off_r  <= '0;
      end else begin
         on_r   <= on_nxt;
         soa_r  <= soa_nxt;
         miss_r <= miss_nxt;
         off_r  <= off_nxt;
      end
   end

   property p_fast_trip;
      @(posedge clock) disable iff (sys_rst) live && pif.cond_soa_high |=> !on_r;
   endproperty
   a_fast_trip: assert property (p_fast_trip) else $error("high current did not trip");
   property p_no_early;
      @(posedge clock) disable iff (sys_rst)
         live && !pif.cond_soa_high && soa_r < W'(SOA_Q - 1) && miss_r < W'(MISS_Q - 1)
         |=> on_r;
   endproperty
   a_no_early: assert property (p_no_early) else $error("channel tripped early");
   property p_miss_trip;
      @(posedge clock) disable iff (sys_rst)
         live && pif.cond_miss && miss_r == W'(MISS_Q - 1) |=> !on_r;
   endproperty
   a_miss_trip: assert property (p_miss_trip) else $error("missing current no trip");
   property p_off_hold;
      @(posedge clock) disable iff (sys_rst)
         pif.active && !on_r && off_r < W'(OFF_C - 1) ##1 pif.active |-> !on_r;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("off period cut short");
endmodule // apms_chan_prot

// *** core/apms_sequencer.sv ***
`include "apms_defines.svh"
module apms_sequencer
   import apms_pkg::*;
#(
   parameter int SOA_QUAL_CYC  = `APMS_CYC_SOA_QUAL,
   parameter int MISS_QUAL_CYC = `APMS_CYC_MISS_QUAL,
   parameter int OFF_CYC       = `APMS_CYC_OFF,
   parameter int SOFT_CYC      = `APMS_CYC_SOFT_MUTE,
   parameter int FAST_CYC      = `APMS_CYC_FAST_MUTE
) (
   input  wire logic       clock,
   input  wire logic       sys_rst,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata_r,
   input  wire logic [3:0] out_below_1v,
   input  wire logic [3:0] load_above_4a,
   input  wire logic [3:0] load_above_8a,
   input  wire logic [3:0] out_below_1v75,
   input  wire logic [3:0] miss_above_1a,
   input  wire logic [3:0] miss_above_3a,
   input  wire logic       standby_control_pin,
   input  wire logic       standby_above_mute,
   input  wire logic       standby_above_oper,
   input  wire logic       address_select_pin_grounded,
   input  wire logic       supply_below_reset,
   input  wire logic       supply_below_low_mute,
   input  wire logic       headroom_low,
   input  wire logic       ripple_filter_node_discharged,
   input  wire logic       ramp_final_step,
   output logic            amp_enable_r,
   output logic      [3:0] chan_enable_r,
   output logic      [1:0] pair_full_mute_r,
   output logic      [1:0] pair_unmuted_r,
   output logic            ripple_filter_node_charge_r,
   output logic            low_pop_slow_r,
   output logic            ripple_filter_node_discharge_r,
   output logic            ac_ground_node_discharge_r,
   output logic            bus_lines_active_r,
   output logic            fault_indicator_pin_out_r,
   output logic            fault_indicator_pin_oe_r
);
   localparam int MW = $clog2(SOFT_CYC + 1);
   localparam int FW = $clog2(FAST_CYC + 1);
   localparam int SYNC_W = 33;
   if (SOFT_CYC < 2 || FAST_CYC < 2 || FAST_CYC > SOFT_CYC) begin : g_chk
      $error("apms_sequencer: mute counts out of range");
   end

   // Comparator levels come from analogue blocks on no clock at all
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   wire  [SYNC_W-1:0] raw = {out_below_1v, load_above_4a, load_above_8a, out_below_1v75,
                             miss_above_1a, miss_above_3a, standby_control_pin,
                             standby_above_mute, standby_above_oper,
                             address_select_pin_grounded, supply_below_reset,
                             supply_below_low_mute, headroom_low,
                             ripple_filter_node_discharged, ramp_final_step};
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= raw;
         sync2_r <= sync1_r;
      end
   end

   wire [3:0] s_lt1v   = sync2_r[32:29];
   wire [3:0] s_gt4a   = sync2_r[28:25];
   wire [3:0] s_gt8a   = sync2_r[24:21];
   wire [3:0] s_lt1v75 = sync2_r[20:17];
   wire [3:0] s_gt1a   = sync2_r[16:13];
   wire [3:0] s_gt3a   = sync2_r[12:9];
   wire s_stb_high     = sync2_r[8];
   wire s_stb_mute     = sync2_r[7];
   wire s_stb_oper     = sync2_r[6];
   wire legacy         = sync2_r[5];
   wire s_sup_reset    = sync2_r[4];
   wire s_sup_low_mute = sync2_r[3];
   wire s_headroom     = sync2_r[2];
   wire s_discharged   = sync2_r[1];
   wire s_final_step   = sync2_r[0];

   apms_state_t state_r;
   apms_state_t state_nxt;
   logic [7:0]  instr1_r;
   logic [7:0]  instr2_r;
   logic        reset_flag_r;
   logic        stb_prev_r;
   logic        released_r;
   logic [FW-1:0] fast_cnt_r;
   logic [MW-1:0] mcnt_r [2];
   logic [MW-1:0] mcnt_nxt [2];
   logic [3:0]  chan_on;

   // Legacy: mute or operating level both count as "on"
   wire stb_on     = legacy ? s_stb_mute : s_stb_high;
   wire stb_rise   = stb_on & !stb_prev_r;
   wire amp_state  = (state_r == ST_RAMP) | (state_r == ST_RUN) | (state_r == ST_FAST_MUTE);
   wire bus_drop   = !legacy & s_sup_reset & (state_r != ST_STANDBY);
   wire legacy_drop = legacy & s_sup_reset & amp_state;
   wire por_evt    = (!legacy & stb_rise) | bus_drop;
   wire wr_ok      = reg_wr & !legacy & stb_on;
   wire start_wr   = wr_ok & (reg_addr == `APMS_REG_INSTR_ONE) & reg_wdata[`APMS_I1_START];
   wire fast_bit   = !legacy & instr2_r[`APMS_I2_FAST_MUTE];
   wire fast_run   = (state_r == ST_FAST_MUTE) | ((state_r == ST_RUN) & fast_bit);
   wire fast_done  = fast_run & (fast_cnt_r == FW'(FAST_CYC - 1));
   wire hard_mute  = (state_r == ST_HR) | (state_r == ST_LOW_SUPPLY);
   wire force_mute = !released_r | (state_r != ST_RUN);
   wire leg_mute   = legacy & s_stb_mute & !s_stb_oper;
   wire [1:0] soft_bits = legacy ? {leg_mute, leg_mute} :
                          {instr2_r[`APMS_I2_SOFT_REAR], instr2_r[`APMS_I2_SOFT_FRONT]};
   wire mute_bits_clear = legacy ? s_stb_oper : (instr2_r[2:0] == 3'h0);
   wire [1:0] mute_want = soft_bits | {2{force_mute | fast_run}};
   wire [1:0] full_nxt, open_nxt;

   // Front pair is channels 1 and 3, rear pair channels 2 and 4
   genvar gp;
   for (gp = 0; gp < 2; gp++) begin : g_pair
      assign mcnt_nxt[gp] = (hard_mute | fast_done) ? MW'(SOFT_CYC) :
                            (mute_want[gp] & (mcnt_r[gp] != MW'(SOFT_CYC))) ?
                               mcnt_r[gp] + MW'(1) :
                            (!mute_want[gp] & (mcnt_r[gp] != '0)) ?
                               mcnt_r[gp] - MW'(1) : mcnt_r[gp];
      assign full_nxt[gp] = (mcnt_nxt[gp] == MW'(SOFT_CYC));
      assign open_nxt[gp] = (mcnt_nxt[gp] == '0);
      always_ff @(posedge clock) begin
         if (sys_rst) begin
            mcnt_r[gp] <= MW'(SOFT_CYC);
         end else begin
            mcnt_r[gp] <= mcnt_nxt[gp];
         end
      end
   end

   wire both_full = (mcnt_r[0] == MW'(SOFT_CYC)) & (mcnt_r[1] == MW'(SOFT_CYC));

   always_comb begin
      state_nxt = state_r;
      if (bus_drop) begin
         state_nxt = ST_POR;
      end else if (legacy_drop) begin
         state_nxt = ST_SHUTDOWN;
      end else begin
         case (state_r)
            ST_STANDBY: begin
               if (stb_on && legacy && !s_sup_reset) begin
                  state_nxt = ST_RAMP;
               end else if (stb_on && !legacy) begin
                  state_nxt = ST_POR;
               end
            end
            ST_POR: begin
               if (!stb_on) begin
                  state_nxt = ST_STANDBY;
               end else if (instr1_r[`APMS_I1_START]) begin
                  state_nxt = ST_RAMP;
               end
            end
            ST_RAMP: begin
               if (!stb_on) begin
                  state_nxt = ST_FAST_MUTE;
               end else if (s_headroom) begin
                  state_nxt = ST_HR;
               end else if (s_final_step) begin
                  state_nxt = ST_RUN;
               end
            end
            ST_RUN: begin
               if (!stb_on) begin
                  state_nxt = ST_FAST_MUTE;
               end else if (s_headroom) begin
                  state_nxt = ST_HR;
               end
            end
            ST_FAST_MUTE: begin
               if (fast_done) begin
                  state_nxt = ST_SHUTDOWN;
               end
            end
            ST_SHUTDOWN: begin
               if (s_discharged) begin
                  state_nxt = ST_STANDBY;
               end
            end
            ST_HR: begin
               if (s_discharged) begin
                  state_nxt = s_sup_low_mute ? ST_LOW_SUPPLY : ST_RAMP;
               end
            end
            ST_LOW_SUPPLY: begin
               if (!stb_on) begin
                  state_nxt = ST_STANDBY;
               end else if (!s_sup_low_mute) begin
                  state_nxt = ST_RAMP;
               end
            end
            default: state_nxt = ST_STANDBY;
         endcase
      end
   end

   // Protection conditions per channel
   apms_chan_if cif [4] ();
   genvar gc;
   for (gc = 0; gc < 4; gc++) begin : g_chan
      assign cif[gc].active        = amp_state;
      assign cif[gc].cond_soa_low  = s_lt1v[gc] & s_gt4a[gc];
      assign cif[gc].cond_soa_high = !s_lt1v[gc] & s_gt8a[gc];
      assign cif[gc].cond_miss     = s_lt1v75[gc] ? s_gt1a[gc] : s_gt3a[gc];
      assign chan_on[gc]           = cif[gc].chan_on;
      apms_chan_prot #(
         .SOA_Q  (SOA_QUAL_CYC),
         .MISS_Q (MISS_QUAL_CYC),
         .OFF_C  (OFF_CYC)
      ) u_prot (
         .clock   (clock),
         .sys_rst (sys_rst),
         .pif     (cif[gc])
      );
   end

   wire load_fault_indicator_pin = legacy | !instr2_r[`APMS_I2_FAULT_INDICATOR_PIN_LOAD_OFF];
   wire chan_fault = amp_state & (chan_on != 4'hf);
   wire flag_nxt   = por_evt | (reset_flag_r & !start_wr);
   wire fault_indicator_pin_nxt   = (!legacy & flag_nxt) | s_sup_low_mute |
                     (chan_fault & load_fault_indicator_pin);
   wire [7:0] status_val = {reset_flag_r, 2'b00, legacy, ~chan_on};
   wire [7:0] rd_mux = (reg_addr == `APMS_REG_INSTR_ONE) ? instr1_r :
                       (reg_addr == `APMS_REG_INSTR_TWO) ? instr2_r :
                       (reg_addr == `APMS_REG_STATUS)    ? status_val :
                       (reg_addr == `APMS_REG_STATE)     ? {4'h0, state_r} : 8'h00;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_r      <= ST_STANDBY;
         instr1_r     <= `APMS_I1_RST;
         instr2_r     <= `APMS_I2_RST;
         reset_flag_r <= 1'b0;
         stb_prev_r   <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         stb_prev_r   <= stb_on;
         reset_flag_r <= flag_nxt;
         // Supply loss wins over a host write in the same cycle
         if (por_evt) begin
            instr1_r <= `APMS_I1_RST;
            instr2_r <= `APMS_I2_RST;
         end else if (wr_ok && reg_addr == `APMS_REG_INSTR_ONE) begin
            instr1_r <= reg_wdata;
         end else if (wr_ok && reg_addr == `APMS_REG_INSTR_TWO) begin
            instr2_r <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         released_r <= 1'b0;
         fast_cnt_r <= '0;
      end else begin
         released_r <= (state_r == ST_RUN) & (released_r | mute_bits_clear);
         fast_cnt_r <= !fast_run ? '0 : fast_done ? fast_cnt_r : fast_cnt_r + FW'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         amp_enable_r                   <= 1'b0;
         chan_enable_r                  <= 4'h0;
         pair_full_mute_r               <= 2'b11;
         pair_unmuted_r                 <= 2'b00;
         ripple_filter_node_charge_r    <= 1'b0;
         low_pop_slow_r                 <= 1'b0;
         ripple_filter_node_discharge_r <= 1'b0;
         ac_ground_node_discharge_r     <= 1'b0;
         bus_lines_active_r             <= 1'b0;
         fault_indicator_pin_out_r      <= 1'b0;
         fault_indicator_pin_oe_r       <= 1'b0;
         reg_rdata_r                    <= 8'h00;
      end else begin
         amp_enable_r                   <= amp_state;
         chan_enable_r                  <= {4{amp_state}} & chan_on;
         pair_full_mute_r               <= full_nxt;
         pair_unmuted_r                 <= open_nxt;
         ripple_filter_node_charge_r    <= (state_r == ST_RAMP);
         low_pop_slow_r                 <= (state_r == ST_RAMP) &
                                           !instr2_r[`APMS_I2_LOW_POP_OFF];
         ripple_filter_node_discharge_r <= (state_r == ST_SHUTDOWN) |
                                           ((state_r == ST_HR) & both_full);
         ac_ground_node_discharge_r     <= (state_r == ST_HR) & both_full;
         bus_lines_active_r             <= !legacy & stb_on;
         fault_indicator_pin_out_r      <= 1'b0;
         fault_indicator_pin_oe_r       <= fault_indicator_pin_nxt;
         reg_rdata_r                    <= reg_rd ? rd_mux : 8'h00;
      end
   end

   sequence s_stop_req;
      state_r == ST_RUN && !stb_on && !s_sup_reset;
   endsequence
   sequence s_fast_end;
      state_r == ST_FAST_MUTE && fast_done && !s_sup_reset;
   endsequence
   property p_stop_fast;
      @(posedge clock) disable iff (sys_rst)
         s_stop_req |=> state_r == ST_FAST_MUTE && !ripple_filter_node_discharge_r;
   endproperty
   a_stop_fast: assert property (p_stop_fast) else $error("stop skipped fast mute");
   property p_mute_then_drain;
      @(posedge clock) disable iff (sys_rst)
         s_fast_end |=> state_r == ST_SHUTDOWN && pair_full_mute_r == 2'b11
                        ##1 ripple_filter_node_discharge_r;
   endproperty
   a_mute_then_drain: assert property (p_mute_then_drain) else $error("drain order wrong");
   property p_bus_drop;
      @(posedge clock) disable iff (sys_rst)
         bus_drop |=> state_r == ST_POR && reset_flag_r && instr1_r == `APMS_I1_RST
                      ##1 fault_indicator_pin_oe_r && !amp_enable_r;
   endproperty
   a_bus_drop: assert property (p_bus_drop) else $error("supply reset incomplete");
   property p_start_clears;
      @(posedge clock) disable iff (sys_rst)
         state_r == ST_POR && start_wr && !bus_drop && !stb_rise |=> !reset_flag_r;
   endproperty
   a_start_clears: assert property (p_start_clears) else $error("flag not cleared");
   property p_headroom;
      @(posedge clock) disable iff (sys_rst)
         state_r == ST_RUN && s_headroom && stb_on && !s_sup_reset
         ##1 !s_discharged && !s_sup_reset
         |-> state_r == ST_HR ##1 pair_full_mute_r == 2'b11 && !ac_ground_node_discharge_r
             ##1 ac_ground_node_discharge_r;
   endproperty
   a_headroom: assert property (p_headroom) else $error("headroom order wrong");
   property p_low_supply;
      @(posedge clock) disable iff (sys_rst)
         state_r == ST_HR && s_discharged && s_sup_low_mute && !bus_drop
         |=> state_r == ST_LOW_SUPPLY ##1 !amp_enable_r;
   endproperty
   a_low_supply: assert property (p_low_supply) else $error("restart at low supply");
   property p_bus_idle;
      @(posedge clock) disable iff (sys_rst) !legacy && !stb_on |=> !bus_lines_active_r;
   endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("bus loaded in standby");
endmodule // apms_sequencer

// *** verif/apms_host_model.sv ***
module apms_host_model (
   input  wire logic       clock,
   input  wire logic [7:0] reg_rdata_r,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic            standby_control_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {reg_addr, reg_wdata, reg_wr, reg_rd, standby_control_pin} = '0;
   // Data flips after each write so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 q = reg_rdata_r;
   endtask
   task automatic pin(input logic v);
      @(posedge clock);
      standby_control_pin <= v;
   endtask
   task automatic start;
      wr(8'h00, 8'h01);
   endtask
endmodule // apms_host_model

// *** verif/amp_protect_mute_sequencer_tb.sv ***
module amp_protect_mute_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clock = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_r, q;
   logic       reg_wr, reg_rd, standby_control_pin, amp, lpop, dis, foe, bus, sbr, rdis, fin;
   logic       hr, slm, chg, acg, fout, lm, lo, leg;
   logic [3:0] b1v, a4, a8, b175, m1, m3, chen, c;
   logic [1:0] fm, um;
   int         err_count = 0;
   int         num_checks = 0;
   always #4 clock = ~clock;
   apms_host_model h (.clock, .reg_rdata_r, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .standby_control_pin);
   apms_sequencer #(.SOA_QUAL_CYC(8), .MISS_QUAL_CYC(6), .OFF_CYC(20), .SOFT_CYC(40),
      .FAST_CYC(4)) i_dut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_r, .out_below_1v(b1v), .load_above_4a(a4), .load_above_8a(a8),
      .out_below_1v75(b175), .miss_above_1a(m1), .miss_above_3a(m3), .standby_control_pin,
      .standby_above_mute(lm), .standby_above_oper(lo),
      .address_select_pin_grounded(leg), .supply_below_reset(sbr),
      .supply_below_low_mute(slm), .headroom_low(hr),
      .ripple_filter_node_discharged(rdis), .ramp_final_step(fin), .amp_enable_r(amp),
      .chan_enable_r(chen), .pair_full_mute_r(fm), .pair_unmuted_r(um),
      .ripple_filter_node_charge_r(chg), .low_pop_slow_r(lpop),
      .ripple_filter_node_discharge_r(dis), .ac_ground_node_discharge_r(acg),
      .bus_lines_active_r(bus), .fault_indicator_pin_out_r(fout),
      .fault_indicator_pin_oe_r(foe));
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e) begin
         err_count++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Polls the state register; a bounded wait so a stuck sequencer ends the run
   task automatic wait_st(input logic [7:0] s);
      for (int i = 0; i < 300; i++) begin
         h.rd(8'h0c, q);
         if (q === s) return;
      end
      chk(q, s);
      tally_and_finish;
   endtask
   initial begin
      {b1v, a4, a8, b175, m1, m3, sbr, rdis, fin, hr, slm, lm, lo, leg} = '0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (4) @(posedge clock);
      chk(8'({amp, bus, foe, fm}), 8'h03);
      h.pin(1'b1);
      wait_st(8'h01);
      h.rd(8'h08, q);
      chk(8'({amp, bus, foe, q[7]}), 8'h07);
      h.wr(8'h04, 8'h00);
      h.start;
      wait_st(8'h02);
      chk(8'({amp, foe, lpop, fm}), 8'h17);
      chk(8'({chg, fout}), 8'h02);
      fin <= 1'b1;
      wait_st(8'h03);
      repeat (60) @(posedge clock);
      chk(8'(um), 8'h03);
      // One channel per case: the other three must keep running
      for (int k = 0; k < 4; k++) begin
         c = 4'(1 << k);
         b1v <= (k == 0) ? c : 4'h0;
         a4 <= (k == 0) ? c : 4'h0;
         a8 <= (k == 1) ? c : 4'h0;
         b175 <= (k == 2) ? c : 4'h0;
         m1 <= (k == 2) ? c : 4'h0;
         m3 <= (k == 3) ? c : 4'h0;
         repeat (5) @(posedge clock);
         chk(8'(chen), (k == 1) ? 8'({4'h0, ~c}) : 8'h0f);
         repeat (12) @(posedge clock);
         chk(8'({foe, chen}), 8'({1'b1, ~c}));
         {b1v, a4, a8, b175, m1, m3} <= '0;
         repeat (33) @(posedge clock);
         chk(8'({foe, chen}), 8'h0f);
      end
      h.wr(8'h04, 8'h02);
      repeat (50) @(posedge clock);
      chk(8'({fm, um}), 8'h06);
      h.wr(8'h04, 8'h01);
      repeat (8) @(posedge clock);
      chk(8'(fm), 8'h03);
      h.wr(8'h04, 8'h00);
      repeat (60) @(posedge clock);
      chk(8'(um), 8'h03);
      hr <= 1'b1;
      repeat (8) @(posedge clock);
      chk(8'({fm, dis, acg, amp}), 8'h1e);
      {slm, rdis} <= 2'b11;
      wait_st(8'h07);
      chk(8'({amp, foe, chen}), 8'h10);
      {hr, slm, rdis} <= 3'h0;
      wait_st(8'h03);
      sbr <= 1'b1;
      wait_st(8'h01);
      h.rd(8'h00, q);
      chk(8'({amp, foe, q[0]}), 8'h02);
      sbr <= 1'b0;
      repeat (10) @(posedge clock);
      wait_st(8'h01);
      fin <= 1'b0;
      h.wr(8'h04, 8'h18);
      h.start;
      wait_st(8'h02);
      chk(8'(lpop), 8'h00);
      fin <= 1'b1;
      wait_st(8'h03);
      a8 <= 4'h2;
      repeat (6) @(posedge clock);
      chk(8'({foe, chen}), 8'h0d);
      a8 <= 4'h0;
      h.pin(1'b0);
      repeat (4) @(posedge clock);
      chk(8'(dis), 8'h00);
      repeat (6) @(posedge clock);
      chk(8'({fm, dis}), 8'h07);
      rdis <= 1'b1;
      wait_st(8'h00);
      chk(8'({amp, bus}), 8'h00);
      // Legacy mode: the three-level pin alone drives start, mute and stop
      leg <= 1'b1;
      lm <= 1'b1;
      wait_st(8'h03);
      repeat (60) @(posedge clock);
      chk(8'({bus, fm, um}), 8'h0c);
      lo <= 1'b1;
      repeat (10) @(posedge clock);
      chk(8'(um), 8'h00);
      repeat (50) @(posedge clock);
      chk(8'({fm, um}), 8'h03);
      sbr <= 1'b1;
      wait_st(8'h00);
      chk(8'({amp, foe}), 8'h00);
      sbr <= 1'b0;
      wait_st(8'h03);
      {lm, lo} <= 2'b00;
      repeat (10) @(posedge clock);
      chk(8'({amp, fm}), 8'h03);
      tally_and_finish;
   end
endmodule // amp_protect_mute_sequencer_tb
